// File: test/acpi_sleep_state_rail_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module acpi_sleep_state_rail_control_tb;
  import asrc_pkg::*;
  logic clk, rst_n, hsel, hwrite, hready, hresp, s3n, s5n, k33n, k50, m33, lm;
  logic bias, ramp, mok, muv, ssl, ot, sb, ga, d33, d50, mp, me, rg, ms, ck, flt, so, a33n, a50;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [RAIL_COUNT-1:0] uv;
  wire logic [6:0] rails;
  int n_fail, checks_done, i;
  assign rails = {sb, ga, d33, d50, mp, me, ck};

  asrc_chipset_model asrc_chipset_model_inst (.ref_clk_i(clk), .suspend_ram_request_n_o(s3n),
    .soft_off_request_n_o(s5n));
  // Short counts keep the run brief; expectations use the same values
  asrc_core #(.DG_CYC(4), .ENTRY_CYC(20), .LATCH_CYC(30), .WAKE_CYC(40)) asrc_core_inst (
    .ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .suspend_ram_request_n_i(s3n), .soft_off_request_n_i(s5n),
    .dual33_keep_strap_n_i(k33n), .dual50_keep_strap_i(k50), .memory_select_33_i(m33),
    .bias_above_por_i(bias), .standby33_ramp_done_i(ramp), .main_supplies_ok_i(mok),
    .main_supply_uv_i(muv), .soft_start_low_i(ssl), .overtemp_i(ot), .rail_uv_i(uv),
    .standby33_rail_en_o(sb), .active_switch_gate_drive_o(ga), .dual33_standby_drive_o(d33),
    .dual50_standby_switch_drive_o(d50), .memory_internal_pass_en_o(mp), .memory_external_drive_o(me),
    .memory_drive_regulate_o(rg), .memory_select_33_o(ms), .clock_chip_rail_en_o(ck),
    .fault_and_memory_select_o(flt));

  // Rails {standby, gate, dual33 sleep, dual50 sleep, mem pass, mem ext, clock}; st 0 active 1 suspend 2 soft-off
  function automatic logic [6:0] exp_r(input int st, input logic sn, input logic f);
    case (st)
      0: return 7'h63;
      1: return {3'h5, f, 3'h4};
      default: return {2'h2, ~sn, f, 3'h0};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_r(input logic [6:0] e, input int lim);
    int k;
    k = 0;
    while (rails !== e && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk("rails", {25'h0, e}, {25'h0, rails});
    @(posedge clk);
  endtask

  // One miss anywhere in the span counts as one mismatch
  task automatic hold_r(input logic [6:0] e, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(negedge clk);
      if (rails !== e) bad = 1'b1;
    end
    chk("rails_hold", 32'h0, {31'h0, bad});
    @(posedge clk);
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #(100 * 20000);
    n_fail++;
    final_report();
  end

  initial
  begin
    {rst_n, hsel, hwrite, bias, ramp, mok, muv, ssl, ot} = 9'h0;
    {k33n, k50, m33} = 3'h2;
    htrans = HTRANS_IDLE;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    uv = '0;
    void'($urandom(32'h7A4A));
    repeat (12) @(posedge clk);
    chk("reset_rails", 32'h0, {25'h0, rails});
    rst_n <= 1'b1;
    m33 <= 1'($urandom);
    bias <= 1'b1;
    wait_r(7'h40, 20);
    lm = m33;
    ramp <= 1'b1;
    mok <= 1'b1;
    hold_r(7'h40, 50);
    wait_r(7'h63, 100);
    chk("mem_sel", {31'h0, lm}, {31'h0, ms});
    chk("regulate", {31'h0, ~lm}, {31'h0, rg});
    m33 <= ~lm;
    ahb(1'b0, 32'(REG_CONTROL_ADDR), 32'h0);
    chk("control", CTRL_RESET_VALUE, rd);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (i = 0; i < 4; i++)
    begin
      so = i[0];
      k33n <= 1'($urandom);
      k50 <= 1'($urandom);
      repeat (4) @(posedge clk);
      a33n = k33n;
      a50 = k50;
      asrc_chipset_model_inst.request(1'b0, ~so);
      hold_r(7'h63, 20);
      wait_r(exp_r(so ? 2 : 1, a33n, a50), 40);
      k33n <= ~a33n;
      k50 <= ~a50;
      repeat (8) @(posedge clk);
      ahb(1'b0, 32'(REG_STATUS_ADDR), 32'h0);
      chk("status", {27'h0, a50, a33n, so, ~so, 1'b0}, {27'h0, rd[4:0]});
      asrc_chipset_model_inst.request(1'b0, so);
      hold_r(exp_r(so ? 2 : 1, a33n, a50), 40);
      asrc_chipset_model_inst.request(1'b1, 1'b1);
      wait_r(7'h63, 100);
    end
    chk("mem_sel_held", {31'h0, lm}, {31'h0, ms});
    asrc_chipset_model_inst.request(1'b1, 1'b0);
    hold_r(7'h63, 40);
    asrc_chipset_model_inst.request(1'b1, 1'b1);
    asrc_chipset_model_inst.glitch(2);
    hold_r(7'h63, 40);
    uv[RAIL_CLOCK] <= 1'b1;
    // Fault passes two sync flops and one register
    repeat (6) @(posedge clk);
    chk("fault_uv", 32'h1, {31'h0, flt});
    uv[RAIL_CLOCK] <= 1'b0;
    muv <= 1'b1;
    repeat (6) @(posedge clk);
    chk("fault_muv", 32'h1, {31'h0, flt});
    muv <= 1'b0;
    ot <= 1'b1;
    repeat (6) @(posedge clk);
    chk("fault_ot", 32'h1, {31'h0, flt});
    ssl <= 1'b1;
    wait_r(7'h00, 20);
    chk("fault_sd", 32'h0, {31'h0, flt});
    ssl <= 1'b0;
    ot <= 1'b0;
    wait_r(7'h63, 200);
    ahb(1'b1, 32'(REG_CONTROL_ADDR), 32'h1);
    wait_r(7'h00, 20);
    ahb(1'b0, 32'(REG_CONTROL_ADDR), 32'h0);
    chk("control_rw", 32'h1, rd);
    ahb(1'b1, 32'(REG_CONTROL_ADDR), 32'h0);
    wait_r(7'h63, 200);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("reset_mid", 32'h0, {25'h0, rails});
    rst_n <= 1'b1;
    wait_r(7'h63, 200);
    chk("mem_relatch", {31'h0, ~lm}, {31'h0, ms});
    final_report();
  end
endmodule
`default_nettype wire

// File: test/asrc_chipset_model.sv
`timescale 1ns/1ns
`default_nettype none
module asrc_chipset_model
(
  // Clock
  input wire logic ref_clk_i,
  // Sleep request pins, idle high as the pull-ups leave them
  output logic suspend_ram_request_n_o,
  output logic soft_off_request_n_o
);
  initial
  begin
    suspend_ram_request_n_o = 1'b1;
    soft_off_request_n_o = 1'b1;
  end
  // Both pins move on one edge, so no legal move passes through the forbidden pair
  task automatic request(input logic s3n, input logic s5n);
    @(posedge ref_clk_i);
    suspend_ram_request_n_o <= s3n;
    soft_off_request_n_o <= s5n;
  endtask
  // Short low pulse, as noise on a long trace would give
  task automatic glitch(input int cyc);
    @(posedge ref_clk_i);
    suspend_ram_request_n_o <= 1'b0;
    repeat (cyc) @(posedge ref_clk_i);
    suspend_ram_request_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verilog/asrc_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - dual 3.3V rail on in active and suspend; soft-off follows strap
// - dual 5V rail on in active; in sleep only when strap is 1
// - memory rail on in active and suspend, off in soft-off
// - soft-off low with suspend high is illegal; wake, active, entry and sleep states hold, while the end of the latch delay goes to soft-off
// - no direct moves between suspend and soft-off
// - strap changes accepted in every state except suspend, soft-off and the wait for the standby ramp
// - both sleep requests filtered, pulses under about 2us rejected
// - suspend request low starts 200us timer, then soft-off request picks sleep state
// - bias above threshold starts standby 3.3V start-up with no command
// - 3ms after standby ramp, latch straps and memory voltage, then continue
// - clock rail only in active states
// - standby 3.3V regulator on while bias present
// - active switch gate drive asserted in active states
// - standby 5V switch on in sleep when dual 5V stays on
// - standby 3.3V drive on in sleep when dual 3.3V stays on
// - memory from internal pass in suspend, external drive in active
// - memory drive is a switch at 3.3V, regulating at 2.5V
// - each enabled rail monitored for undervoltage, reported as fault
// - fault on output undervoltage, main supply undervoltage in active states, or overtemperature
// - soft-start held low disables all outputs except memory_select_33_o and clears fault
// - power-up into active waits 25ms after main supplies good
// - straps latched on sleep entry, after reset release and shutdown exit
module asrc_core
  import asrc_pkg::*;
#(
  parameter int DG_CYC = DEGLITCH_CYC,
  parameter int ENTRY_CYC = SLEEP_ENTRY_CYC,
  parameter int LATCH_CYC = STRAP_LATCH_CYC,
  parameter int WAKE_CYC = ACTIVE_WAKE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Sleep requests and straps (pins)
  input wire logic suspend_ram_request_n_i,
  input wire logic soft_off_request_n_i,
  input wire logic dual33_keep_strap_n_i,
  input wire logic dual50_keep_strap_i,
  input wire logic memory_select_33_i,
  // Supply and analog monitor status (pins)
  input wire logic bias_above_por_i,
  input wire logic standby33_ramp_done_i,
  input wire logic main_supplies_ok_i,
  input wire logic main_supply_uv_i,
  input wire logic soft_start_low_i,
  input wire logic overtemp_i,
  input wire logic [RAIL_COUNT-1:0] rail_uv_i,
  // Rail drives
  output logic standby33_rail_en_o,
  output logic active_switch_gate_drive_o,
  output logic dual33_standby_drive_o,
  output logic dual50_standby_switch_drive_o,
  output logic memory_internal_pass_en_o,
  output logic memory_external_drive_o,
  output logic memory_drive_regulate_o,
  output logic memory_select_33_o,
  output logic clock_chip_rail_en_o,
  output logic fault_and_memory_select_o
);

  localparam int PIN_W = 11 + RAIL_COUNT;
  // One timer serves all three delays, so it is sized for the longest
  localparam int TMAX = (WAKE_CYC > LATCH_CYC) ? ((WAKE_CYC > ENTRY_CYC) ? WAKE_CYC : ENTRY_CYC) :
                        ((LATCH_CYC > ENTRY_CYC) ? LATCH_CYC : ENTRY_CYC);
  localparam int TW = $clog2(TMAX + 1);
  localparam int DW = $clog2(DG_CYC + 1);

  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  logic susp_raw, soff_raw, str33n_s, str50_s, msel_s, bias_s, sbdone_s, main_ok_s, main_uv_s, ss_low_s, ot_s;
  logic [RAIL_COUNT-1:0] uv_s;
  logic [1:0] req_raw;
  logic [1:0] req_f_ff;
  logic [DW-1:0] dg_cnt_ff [2];
  logic s3f, s5f, illegal_req, shut;
  asrc_state_type state_ff, nxt_state;
  logic [TW-1:0] tmr_ff;
  logic tmr_run, entry_done, latch_done, wake_done;
  logic str33n_ff, str50_ff, mem33_ff, ctrl_shut_ff, fault_ff;
  logic is_active, is_sleep;
  logic d33_on, d50_on, mem_on;
  logic [RAIL_COUNT-1:0] rail_on;
  logic dph_valid_ff, dph_write_ff;
  logic [11:0] dph_addr_ff;
  logic [31:0] status_word;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge ref_clk_i)
  begin
    pin_meta_ff <= {rail_uv_i, overtemp_i, soft_start_low_i, main_supply_uv_i, main_supplies_ok_i,
                    standby33_ramp_done_i, bias_above_por_i, memory_select_33_i, dual50_keep_strap_i,
                    dual33_keep_strap_n_i, soft_off_request_n_i, suspend_ram_request_n_i};
    pin_sync_ff <= pin_meta_ff;
  end

  assign {uv_s, ot_s, ss_low_s, main_uv_s, main_ok_s, sbdone_s, bias_s, msel_s, str50_s, str33n_s, soff_raw,
          susp_raw} = pin_sync_ff;
  assign req_raw = {soff_raw, susp_raw};

  // A request level is taken only after it has stood for the full window
  for (genvar g = 0; g < 2; g++)
  begin : g_deglitch
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        req_f_ff[g] <= 1'b1;
        dg_cnt_ff[g] <= '0;
      end
      else if (req_raw[g] == req_f_ff[g])
        dg_cnt_ff[g] <= '0;
      else if (dg_cnt_ff[g] == DW'(DG_CYC - 1))
      begin
        req_f_ff[g] <= req_raw[g];
        dg_cnt_ff[g] <= '0;
      end
      else
        dg_cnt_ff[g] <= dg_cnt_ff[g] + 1'b1;
    end
  end

  assign s3f = req_f_ff[0];
  assign s5f = req_f_ff[1];
  assign illegal_req = s3f && !s5f;
  assign shut = ss_low_s || ctrl_shut_ff;

  assign entry_done = (tmr_ff == TW'(ENTRY_CYC - 1));
  assign latch_done = (tmr_ff == TW'(LATCH_CYC - 1));
  assign wake_done = (tmr_ff == TW'(WAKE_CYC - 1));

  // Power state sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR:
        if (bias_s)
          nxt_state = ST_SB_RAMP;
      ST_SB_RAMP:
        if (sbdone_s)
          nxt_state = ST_LATCH;
      ST_LATCH:
        if (latch_done)
        begin
          if (s3f && s5f)
            nxt_state = ST_WAKE;
          else if (!s3f && s5f)
            nxt_state = ST_SUSPEND;
          else
            nxt_state = ST_SOFTOFF;
        end
      ST_WAKE:
        if (!s3f)
          nxt_state = s5f ? ST_SUSPEND : ST_SOFTOFF;
        else if (wake_done && main_ok_s && !illegal_req)
          nxt_state = ST_ACTIVE;
      ST_ACTIVE:
        if (!s3f)
          nxt_state = ST_ENTRY;
      ST_ENTRY:
        if (s3f && s5f)
          nxt_state = ST_ACTIVE;
        else if (!s3f && entry_done)
          nxt_state = s5f ? ST_SUSPEND : ST_SOFTOFF;
      ST_SUSPEND, ST_SOFTOFF:
        if (s3f && s5f)
          nxt_state = ST_WAKE;
      default:
        nxt_state = ST_POR;
    endcase
    if (!bias_s || shut)
      nxt_state = ST_POR;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_ff <= ST_POR;
    else
      state_ff <= nxt_state;
  end

  // Holding the timer under an illegal request freezes the entry delay too
  assign tmr_run = (state_ff == ST_LATCH) || (state_ff == ST_WAKE && main_ok_s && !illegal_req) ||
                   (state_ff == ST_ENTRY && !illegal_req);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      tmr_ff <= '0;
    else if (nxt_state != state_ff || (state_ff == ST_WAKE && !main_ok_s))
      tmr_ff <= '0;
    else if (tmr_run)
      tmr_ff <= tmr_ff + 1'b1;
  end

  // Straps track the pins except in sleep and in the wait for the standby ramp
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      str33n_ff <= 1'b0;
      str50_ff <= 1'b1;
    end
    else if (state_ff != ST_SUSPEND && state_ff != ST_SOFTOFF && state_ff != ST_SB_RAMP)
    begin
      str33n_ff <= str33n_s;
      str50_ff <= str50_s;
    end
  end

  // Memory voltage is only sampled once per start-up, at the end of the latch delay
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      mem33_ff <= 1'b0;
    else if (state_ff == ST_LATCH && latch_done)
      mem33_ff <= msel_s;
  end

  assign is_active = (state_ff == ST_ACTIVE) || (state_ff == ST_ENTRY);
  assign is_sleep = (state_ff == ST_SUSPEND) || (state_ff == ST_SOFTOFF);
  assign d33_on = is_active || state_ff == ST_SUSPEND || (state_ff == ST_SOFTOFF && !str33n_ff);
  assign d50_on = is_active || (is_sleep && str50_ff);
  assign mem_on = is_active || state_ff == ST_SUSPEND;
  assign rail_on = {is_active, mem_on, d50_on, d33_on, state_ff != ST_POR};

  // Rail drives
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      standby33_rail_en_o <= 1'b0;
      active_switch_gate_drive_o <= 1'b0;
      dual33_standby_drive_o <= 1'b0;
      dual50_standby_switch_drive_o <= 1'b0;
      memory_internal_pass_en_o <= 1'b0;
      memory_external_drive_o <= 1'b0;
      memory_drive_regulate_o <= 1'b0;
      memory_select_33_o <= 1'b0;
      clock_chip_rail_en_o <= 1'b0;
    end
    else
    begin
      standby33_rail_en_o <= bias_s && !shut;
      active_switch_gate_drive_o <= is_active;
      dual33_standby_drive_o <= is_sleep && d33_on;
      dual50_standby_switch_drive_o <= is_sleep && d50_on;
      memory_internal_pass_en_o <= is_sleep && mem_on;
      memory_external_drive_o <= is_active;
      memory_drive_regulate_o <= is_active && !mem33_ff;
      memory_select_33_o <= mem33_ff;
      clock_chip_rail_en_o <= is_active;
    end
  end

  // Monitoring a rail that is off would flag its expected low voltage
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      fault_ff <= 1'b0;
    else
      fault_ff <= !shut && ((|(uv_s & rail_on)) || (is_active && main_uv_s) || ot_s);
  end

  assign fault_and_memory_select_o = fault_ff;

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      dph_valid_ff <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_addr_ff <= 12'h000;
    end
    else if (hready_i)
    begin
      dph_valid_ff <= hsel_i && htrans_i[1];
      dph_write_ff <= hwrite_i;
      dph_addr_ff <= haddr_i[11:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      ctrl_shut_ff <= CTRL_RESET_VALUE[CTRL_SHUTDOWN_BIT];
    else if (dph_valid_ff && dph_write_ff && dph_addr_ff == REG_CONTROL_ADDR)
      ctrl_shut_ff <= hwdata_i[CTRL_SHUTDOWN_BIT];
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_ACTIVE_BIT] = is_active;
    status_word[STAT_SUSPEND_BIT] = state_ff == ST_SUSPEND;
    status_word[STAT_SOFTOFF_BIT] = state_ff == ST_SOFTOFF || state_ff == ST_POR;
    status_word[STAT_DUAL33_KEEP_N_BIT] = str33n_ff;
    status_word[STAT_DUAL50_KEEP_BIT] = str50_ff;
    status_word[STAT_MEM33_BIT] = mem33_ff;
    status_word[STAT_FAULT_BIT] = fault_ff;
    status_word[STAT_WAKE_BIT] = state_ff == ST_WAKE;
    status_word[STAT_UV_LSB +: RAIL_COUNT] = uv_s;
  end

  // Read data is captured in the address phase so it stands through the data phase
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
    begin
      if (haddr_i[11:0] == REG_CONTROL_ADDR)
        hrdata_o <= {31'h0000_0000, ctrl_shut_ff};
      else if (haddr_i[11:0] == REG_STATUS_ADDR)
        hrdata_o <= status_word;
      else
        hrdata_o <= 32'h0000_0000;
    end
  end

  // Checks
  sequence s_sleep_entry;
    state_ff == ST_ENTRY && !s3f && entry_done;
  endsequence

  sequence s_shutdown;
    shut && rst_n_i;
  endsequence

  chk_clock_active_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clock_chip_rail_en_o |-> $past(is_active))
    else $error("clock rail on outside active");

  chk_illegal_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (illegal_req && bias_s && !shut && state_ff inside {ST_SUSPEND, ST_SOFTOFF, ST_ENTRY, ST_WAKE, ST_ACTIVE})
    |=> $stable(state_ff))
    else $error("state moved under illegal request");

  chk_no_sleep_swap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_SUSPEND |=> state_ff != ST_SOFTOFF) and (state_ff == ST_SOFTOFF |=> state_ff != ST_SUSPEND))
    else $error("direct move between sleep states");

  chk_entry_choice: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_sleep_entry and (bias_s && !shut)) |=> (state_ff == (($past(s5f)) ? ST_SUSPEND : ST_SOFTOFF)))
    else $error("wrong sleep state after entry delay");

  chk_dual33_softoff: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_SOFTOFF && str33n_ff) |=> !dual33_standby_drive_o && !active_switch_gate_drive_o)
    else $error("dual 3.3V rail on in soft-off with strap set");

  chk_dual50_sleep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (is_sleep) |=> (dual50_standby_switch_drive_o == $past(str50_ff)))
    else $error("standby 5V switch does not follow strap in sleep");

  chk_mem_softoff: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_ff == ST_SOFTOFF |=> !memory_internal_pass_en_o && !memory_external_drive_o)
    else $error("memory rail on in soft-off");

  chk_deglitch_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(req_f_ff) |-> ($past(dg_cnt_ff[0]) == DW'(DG_CYC - 1)) || ($past(dg_cnt_ff[1]) == DW'(DG_CYC - 1)))
    else $error("request filter switched early");

  chk_shutdown_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_shutdown ##1 shut ##1 shut |-> !fault_and_memory_select_o && !standby33_rail_en_o && !clock_chip_rail_en_o)
    else $error("outputs or fault active in shutdown");

  chk_wake_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_WAKE ##1 state_ff == ST_ACTIVE) |-> $past(wake_done) && $past(main_ok_s))
    else $error("active entered before wake delay");

  chk_strap_frozen: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (is_sleep ##1 is_sleep) |-> $stable(str33n_ff) && $stable(str50_ff))
    else $error("strap changed while asleep");

  chk_mem_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    memory_external_drive_o |-> (memory_drive_regulate_o == !memory_select_33_o))
    else $error("memory drive mode does not match voltage");

endmodule
`default_nettype wire

// File: verilog/asrc_pkg.sv
package asrc_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEGLITCH_TIME_NS = 2000;
  localparam int SLEEP_ENTRY_TIME_US = 200;
  localparam int STRAP_LATCH_TIME_MS = 3;
  localparam int ACTIVE_WAKE_TIME_MS = 25;
  localparam int DEGLITCH_CYC = (DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int STRAP_LATCH_CYC = (STRAP_LATCH_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int ACTIVE_WAKE_CYC = (ACTIVE_WAKE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // Register map (byte addresses)
  localparam logic [11:0] REG_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] REG_STATUS_ADDR = 12'h004;

  // Control register fields
  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;

  // Status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_SUSPEND_BIT = 1;
  localparam int STAT_SOFTOFF_BIT = 2;
  localparam int STAT_DUAL33_KEEP_N_BIT = 3;
  localparam int STAT_DUAL50_KEEP_BIT = 4;
  localparam int STAT_MEM33_BIT = 5;
  localparam int STAT_FAULT_BIT = 6;
  localparam int STAT_WAKE_BIT = 7;
  localparam int STAT_UV_LSB = 8;

  // Rail index within the undervoltage vector
  localparam int RAIL_COUNT = 5;
  localparam int RAIL_STANDBY33 = 0;
  localparam int RAIL_DUAL33 = 1;
  localparam int RAIL_DUAL50 = 2;
  localparam int RAIL_MEMORY = 3;
  localparam int RAIL_CLOCK = 4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ST_POR,
    ST_SB_RAMP,
    ST_LATCH,
    ST_WAKE,
    ST_ACTIVE,
    ST_ENTRY,
    ST_SUSPEND,
    ST_SOFTOFF
  } asrc_state_type;
endpackage
